// ---- dv/mrq_chk.sv ----
// port checker for the motion qualifier
`timescale 1ns/10ps
`default_nettype none
`include "mrq_map.svh"
module mrq_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // sensors and angle
  input wire mrq_pkg::sensor_vec_t motion_pin,
  input wire mrq_pkg::count_t display_angle,
  // control and view
  input wire logic motor_drive_enable,
  input wire logic idle_mode,
  input wire logic display_power_off,
  input wire mrq_pkg::sensor_state_t [`SENSOR_COUNT-1:0] sensor_state,
  input wire mrq_pkg::count_t north_angle,
  input wire mrq_pkg::count_t idle_angle
);
  import mrq_pkg::*;
  sensor_vec_t trig_v;
  // triggered flags gathered from the state view
  always_comb begin
    for (int i = 0; i < `SENSOR_COUNT; i++) begin
      trig_v[i] = (sensor_state[i] == SENS_TRIGGERED);
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // ****************************************************
  // checks
  // ****************************************************
  a_rdata_quiet: assert property (
    !$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside read answer");
  a_pin_activates: assert property (
    motion_pin[0] [*3] |=> sensor_state[0] != SENS_INACTIVE)
    else $error("sensor 0 not active on movement");
  a_pin_releases: assert property (
    !motion_pin[5] [*3] |=> sensor_state[5] == SENS_INACTIVE)
    else $error("sensor 5 not inactive without movement");
  a_trig_needs_pin: assert property (
    sensor_state[3] == SENS_TRIGGERED |-> $past(motion_pin[3], 3))
    else $error("sensor 3 triggered without movement");
  a_start_cause: assert property (
    $rose(motor_drive_enable) |-> |$past(trig_v))
    else $error("motor started with no triggered sensor");
  a_north_capture: assert property (
    $changed(north_angle) |-> north_angle == $past(display_angle)
      && !$past(motor_drive_enable) && $past(reg_wr))
    else $error("north angle captured wrongly");
  a_idle_capture: assert property (
    $changed(idle_angle) |-> idle_angle == $past(display_angle)
      && !$past(motor_drive_enable) && $past(reg_wr))
    else $error("idle angle captured wrongly");
  a_moving_wakes: assert property (
    motor_drive_enable [*2] |-> !idle_mode && !display_power_off)
    else $error("idle while moving");
  a_idle_stopped: assert property (
    $rose(idle_mode) |-> !$past(motor_drive_enable) && !motor_drive_enable)
    else $error("idle entered while moving");
  a_off_in_idle: assert property (
    display_power_off |-> idle_mode)
    else $error("display off outside idle");
  // main scenarios
  c_start: cover property ($rose(motor_drive_enable));
  c_stop: cover property ($fell(motor_drive_enable));
  c_disp_off: cover property ($rose(display_power_off));
endmodule // mrq_chk
bind motion_reactivity_qualifier mrq_chk i_mrq_chk (.clk(clk), .rstn(rstn),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .motion_pin(motion_pin),
  .display_angle(display_angle), .motor_drive_enable(motor_drive_enable),
  .idle_mode(idle_mode), .display_power_off(display_power_off),
  .sensor_state(sensor_state), .north_angle(north_angle),
  .idle_angle(idle_angle));
`default_nettype wire

// ---- dv/sensor_field_model.sv ----
// far side model: motion sensors and stepper drive turning the display
`timescale 1ns/10ps
`default_nettype none
`include "mrq_map.svh"
module sensor_field_model (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // scene set by the bench
  input wire mrq_pkg::sensor_vec_t presence,
  input wire mrq_pkg::count_t hand_angle,
  input wire logic hand_set,
  // drive enable from the block
  input wire logic motor_drive_enable,
  // sensor levels and present angle
  output mrq_pkg::sensor_vec_t motion_pin,
  output mrq_pkg::count_t display_angle
);
  import mrq_pkg::*;
  // push-pull detector outputs follow presence
  assign motion_pin = presence;
  // one step a clock while driven; hand turning only with drive off
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      display_angle <= 16'h0000;
    end else if (motor_drive_enable) begin
      display_angle <= display_angle + 16'h0001;
    end else if (hand_set) begin
      display_angle <= hand_angle;
    end
  end
endmodule // sensor_field_model
`default_nettype wire

// ---- dv/tb_top.sv ----
// self-checking bench for the motion qualifier
`timescale 1ns/10ps
`default_nettype none
`include "mrq_map.svh"
module tb_top;
  import mrq_pkg::*;
  logic clk, rstn, reg_wr, reg_rd, hand_set;
  logic motor_drive_enable, idle_mode, display_power_off;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, rv;
  sensor_vec_t motion_pin, presence;
  count_t display_angle, hand_angle, north_angle, idle_angle;
  sensor_state_t [`SENSOR_COUNT-1:0] sensor_state;
  int failures, checked;
  localparam logic [15:0] RST_TAB [8] = '{16'h0003, `RST_ON_TIME,
    16'(`RST_TRIG_PCT), 16'(`RST_START_CNT), 16'(`RST_STOP_CNT),
    `RST_STOP_HOLD, `RST_IDLE_WAIT, `RST_DISP_WAIT};
  localparam logic [15:0] CFG [8] = '{16'h0000, 16'h000a, 16'h0028,
    16'h0003, 16'h0003, 16'h0014, 16'h001e, 16'h000f};
  localparam logic [7:0] NEG_PIN [2] = '{8'h15, 8'h03};
  localparam logic [15:0] NEG_ST [2] = '{16'h0222, 16'h000a};

  motion_reactivity_qualifier #(.TICK_DIV_RST(3))
    i_motion_reactivity_qualifier (.clk(clk), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .motion_pin(motion_pin),
    .display_angle(display_angle), .motor_drive_enable(motor_drive_enable),
    .idle_mode(idle_mode), .display_power_off(display_power_off),
    .sensor_state(sensor_state), .north_angle(north_angle),
    .idle_angle(idle_angle));
  sensor_field_model i_sensor_field_model (.clk(clk), .rstn(rstn),
    .presence(presence), .hand_angle(hand_angle), .hand_set(hand_set),
    .motor_drive_enable(motor_drive_enable), .motion_pin(motion_pin),
    .display_angle(display_angle));

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ****************************************************
  // bus and compare tasks
  // ****************************************************
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  task automatic pins(input logic [7:0] v);
    @(posedge clk);
    presence <= v;
    #1;
  endtask
  task automatic hand(input logic [15:0] a);
    @(posedge clk);
    hand_angle <= a;
    hand_set <= 1'b1;
    @(posedge clk);
    hand_set <= 1'b0;
    #1;
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // watchdog, well beyond the roughly 470 cycles the tests take
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    wrap_up();
  end
  // main sequence
  initial begin
    rstn = 1'b0;
    {reg_wr, reg_rd, hand_set} = 3'h0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    presence = 8'h00;
    hand_angle = 16'h0000;
    failures = 0;
    checked = 0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    cyc(1);
    for (int i = 0; i < 8; i++) begin
      rd(8'(i + 1), rv);
      cmp(rv, RST_TAB[i]);
      wr(8'(i + 1), CFG[i]);
      rd(8'(i + 1), rv);
      cmp(rv, CFG[i]);
    end
    rd(`ADDR_CMD, rv);
    cmp(rv & 16'h0003, 16'h0002);
    rd(8'h0c, rv);
    cmp(rv, 16'h0000);
    // one sensor at a time, checked as active before it triggers
    for (int i = 0; i < 8; i++) begin
      pins(8'(1 << i));
      cyc(5);
      cmp(16'(sensor_state), 16'(SENS_ACTIVE) << (2 * i));
      pins(8'h00);
      cyc(5);
    end
    // enough triggered sensors but no neighbours, or too few
    for (int k = 0; k < 2; k++) begin
      pins(NEG_PIN[k]);
      cyc(30);
      cmp(16'(sensor_state), NEG_ST[k]);
      cmp(16'(motor_drive_enable), 16'h0000);
      pins(8'h00);
      cyc(6);
    end
    // pair across the ring wrap, full time reached later
    pins(8'h89);
    cyc(9);
    cmp(16'(sensor_state), 16'h8082);
    rd(`ADDR_SENSORS, rv);
    cmp(rv, 16'h8989);
    cmp(16'(motor_drive_enable), 16'h0000);
    cyc(16);
    cmp(16'(motor_drive_enable), 16'h0001);
    cmp(16'({idle_mode, display_power_off}), 16'h0000);
    cyc(40);
    cmp(16'(motor_drive_enable), 16'h0001);
    // two left triggered: below stop count
    pins(8'h09);
    cyc(15);
    cmp(16'(motor_drive_enable), 16'h0001);
    cyc(17);
    cmp(16'(motor_drive_enable), 16'h0000);
    pins(8'h00);
    cyc(14);
    cmp(16'({idle_mode, display_power_off}), 16'h0000);
    cyc(16);
    cmp(16'({idle_mode, display_power_off}), 16'h0002);
    cyc(6);
    cmp(16'(display_power_off), 16'h0000);
    cyc(10);
    cmp(16'(display_power_off), 16'h0001);
    // toggle while locked is ignored, unlocked toggle stops motion
    wr(`ADDR_CMD, 16'h0004);
    pins(8'h89);
    cyc(30);
    cmp(16'(motor_drive_enable), 16'h0001);
    cmp(16'({idle_mode, display_power_off}), 16'h0000);
    wr(`ADDR_CMD, 16'h0001);
    wr(`ADDR_CMD, 16'h0004);
    cyc(1);
    cmp(16'(motor_drive_enable), 16'h0000);
    rd(`ADDR_CMD, rv);
    cmp(rv, 16'h0001);
    cyc(30);
    cmp(16'(motor_drive_enable), 16'h0000);
    // calibration with the drive off, display turned by hand
    pins(8'h00);
    hand(16'h1234);
    wr(`ADDR_CMD, 16'h0008);
    cyc(1);
    cmp(north_angle, 16'h1234);
    hand(16'h0567);
    wr(`ADDR_CMD, 16'h0010);
    cyc(1);
    cmp(idle_angle, 16'h0567);
    rd(`ADDR_NORTH, rv);
    cmp(rv, 16'h1234);
    rd(`ADDR_IDLE_ANGLE, rv);
    cmp(rv, 16'h0567);
    wr(`ADDR_CMD, 16'h0002);
    hand(16'h0abc);
    wr(`ADDR_CMD, 16'h0008);
    cyc(1);
    cmp(north_angle, 16'h1234);
    wrap_up();
  end
endmodule // tb_top
`default_nettype wire

// ---- src/motion_reactivity_qualifier.sv ----
// top of the motion qualifier: sensors, start/stop, idle and calibration
//
// The register offsets and the address-and-strobe port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "mrq_map.svh"
module motion_reactivity_qualifier #(
  parameter int unsigned TICK_DIV_RST = `TICK_PERIOD_NS / `CLK_PERIOD_NS - 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // motion sensor pins
  input wire mrq_pkg::sensor_vec_t motion_pin,
  // present rotation angle from the position tracker
  input wire mrq_pkg::count_t display_angle,
  // motor and display control
  output logic motor_drive_enable,
  output logic idle_mode,
  output logic display_power_off,
  // qualification view and calibration angles
  output mrq_pkg::sensor_state_t [`SENSOR_COUNT-1:0] sensor_state,
  output mrq_pkg::count_t north_angle,
  output mrq_pkg::count_t idle_angle
);
  import mrq_pkg::*;

  // *****************************************************************
  // register map and timing
  // *****************************************************************

  // 00 write: bit 0 unlock, 1 lock, 2 toggle motion enable,
  //    3 capture north, 4 capture idle angle
  // 00 read: bit 0 unlocked, 1 motion enabled, 2 moving,
  //    3 idle, 4 display off
  // 01 tick divisor, a tick every divisor + 1 clocks
  // 02 on-qualify time
  // 03 trigger fraction in percent, capped at 100
  // 04 start sensor count
  // 05 stop sensor count
  // 06 stop hold time
  // 07 idle wait time
  // 08 display-off wait
  // 09 north angle, read only
  // 0a idle angle, read only
  // 0b active flags low byte, triggered high byte
  // others read zero, writes to them dropped

  // all durations count ticks, not clocks
  // pin change reaches the sensor view on the third edge
  // sensor view codes: 00 inactive, 01 active, 10 triggered
  // start and stop act on the edge after their condition
  // toggle beats a qualified stop, a stop beats a start
  // captures need unlock, motion off and motor stopped
  // lock beats unlock when both come in one write
  // timers saturate; a lowered limit qualifies at once
  // read data stand one cycle, zero otherwise
  // idle timer runs from reset, as no motion is seen
  // sensors sit on a ring, the last next to the first
  // angles come straight from the position tracker

  // *****************************************************************
  // helper functions
  // *****************************************************************

  // number of set bits
  // small loop, folded into an adder
  function automatic num_t ones_f(input sensor_vec_t v);
    num_t n;
    n = 4'h0;
    for (int i = 0; i < `SENSOR_COUNT; i++) begin
      n = num_t'(n + {3'h0, v[i]});
    end
    return n;
  endfunction

  // any two set bits side by side on the ring
  function automatic logic pair_f(input sensor_vec_t v);
    sensor_vec_t rot;
    rot = {v[0], v[`SENSOR_COUNT-1:1]};
    return |(v & rot);
  endfunction

  // trigger ticks: fraction of the on-qualify time, capped at all of it
  // the product needs 23 bits before the division
  function automatic count_t frac_f(input count_t on, input pct_t pct);
    logic [22:0] prod;
    pct_t p;
    p = (pct > `PCT_MAX) ? `PCT_MAX : pct;
    prod = 23'(on) * 23'(p);
    return count_t'(prod / `PCT_DIV);
  endfunction

  // step a duration timer by one tick, stopping at its limit
  // holding at the limit keeps the compare true
  function automatic count_t step_f(input count_t c, input count_t lim,
                                    input logic tk);
    count_t s;
    s = c;
    if (tk && c < lim) begin
      s = count_t'(c + 16'h0001);
    end
    return s;
  endfunction

  // *****************************************************************
  // state and submodules
  // *****************************************************************

  top_state_t r_r;
  top_state_t r_nxt;

  // submodule results
  logic tick;
  count_t trig_ticks;
  sensor_vec_t s_active;
  sensor_vec_t s_trig;
  sensor_vec_t s_full;

  // start and stop decisions
  num_t trig_num;
  logic start_ok;
  logic stop_cond;
  logic stop_done;

  // command decode
  logic cmd_wr;
  logic do_toggle;
  logic cal_ok;

  // time base for all durations
  // one pulse every divisor + 1 clocks
  tick_divider u_tick (
    .clk(clk),
    .rstn(rstn),
    .div(r_r.tick_div),
    .tick(tick)
  );

  // threshold for the triggered state
  assign trig_ticks = frac_f(r_r.on_time, r_r.trig_pct);

  // qualification of each synchronised sensor
  // flags come out registered
  sensor_qualifier u_qual (
    .clk(clk),
    .rstn(rstn),
    .level(r_r.s_sync),
    .tick(tick),
    .on_time(r_r.on_time),
    .trig_ticks(trig_ticks),
    .active(s_active),
    .triggered(s_trig),
    .full(s_full)
  );

  // *****************************************************************
  // start and stop decisions
  // *****************************************************************

  // count, neighbour pair and full-time sensor among the triggered ones
  // the pair test only applies from two sensors up
  always_comb begin
    trig_num = ones_f(s_trig);
    start_ok = (trig_num >= r_r.start_cnt)
               && (r_r.start_cnt < `PAIR_MIN || pair_f(s_trig))
               && (|(s_trig & s_full));
    stop_cond = trig_num < r_r.stop_cnt;
    stop_done = stop_cond && (r_r.stop_tmr >= r_r.stop_hold);
  end

  // toggle and capture commands only count once software has unlocked them
  assign cmd_wr = reg_wr && (reg_addr == `ADDR_CMD);
  assign do_toggle = cmd_wr && reg_wdata[`CMD_TOGGLE]
                     && r_r.unlocked;
  // calibration needs unlock and a disabled, stopped motor
  assign cal_ok = cmd_wr && r_r.unlocked && !r_r.motion_en
                  && !r_r.moving;

  // *****************************************************************
  // next state
  // *****************************************************************

  always_comb begin
    r_nxt = r_r;

    // two-stage synchroniser for the sensor pins
    // only the second stage feeds any logic
    r_nxt.s_meta = motion_pin;
    r_nxt.s_sync = r_r.s_meta;

    // configuration writes
    // counts and fraction keep only their low bits
    if (reg_wr) begin
      case (reg_addr)
        `ADDR_TICK_DIV: r_nxt.tick_div = reg_wdata;
        `ADDR_ON_TIME: r_nxt.on_time = reg_wdata;
        `ADDR_TRIG_PCT: r_nxt.trig_pct = pct_t'(reg_wdata);
        `ADDR_START_CNT: r_nxt.start_cnt = num_t'(reg_wdata);
        `ADDR_STOP_CNT: r_nxt.stop_cnt = num_t'(reg_wdata);
        `ADDR_STOP_HOLD: r_nxt.stop_hold = reg_wdata;
        `ADDR_IDLE_WAIT: r_nxt.idle_wait = reg_wdata;
        `ADDR_DISP_WAIT: r_nxt.disp_wait = reg_wdata;
        default: r_nxt.tick_div = r_r.tick_div;
      endcase
    end

    // unlock is sticky until a lock; lock wins if both are given
    // commands act on the edge of their write
    if (cmd_wr && reg_wdata[`CMD_UNLOCK]) begin
      r_nxt.unlocked = 1'b1;
    end
    if (cmd_wr && reg_wdata[`CMD_LOCK]) begin
      r_nxt.unlocked = 1'b0;
    end

    // angle capture while the display is positioned by hand
    // the tracker shares this clock, so no sync
    if (cal_ok && reg_wdata[`CMD_SET_NORTH]) begin
      r_nxt.north_angle = display_angle;
    end
    if (cal_ok && reg_wdata[`CMD_SET_IDLE]) begin
      r_nxt.idle_angle = display_angle;
    end

    // stop timer runs only while the stop condition holds
    // a dip in the condition restarts the hold
    if (stop_cond) begin
      r_nxt.stop_tmr = step_f(r_r.stop_tmr, r_r.stop_hold, tick);
    end else begin
      r_nxt.stop_tmr = 16'h0000;
    end

    // motion enable toggle, stop and start of the motor
    if (do_toggle) begin
      r_nxt.motion_en = !r_r.motion_en;
      if (r_r.motion_en) begin
        r_nxt.moving = 1'b0;
      end
    end else if (r_r.moving && stop_done) begin
      r_nxt.moving = 1'b0;
    end else if (!r_r.moving && r_r.motion_en && start_ok) begin
      r_nxt.moving = 1'b1;
    end

    // idle and display-off timers while the motor stands
    // a start clears idle and display-off
    if (r_r.moving) begin
      r_nxt.idle_tmr = 16'h0000;
      r_nxt.disp_tmr = 16'h0000;
      r_nxt.idle = 1'b0;
      r_nxt.disp_off = 1'b0;
    end else if (!r_r.idle) begin
      r_nxt.idle_tmr = step_f(r_r.idle_tmr, r_r.idle_wait, tick);
      if (r_r.idle_tmr >= r_r.idle_wait) begin
        r_nxt.idle = 1'b1;
      end
    end else begin
      r_nxt.disp_tmr = step_f(r_r.disp_tmr, r_r.disp_wait, tick);
      if (r_r.disp_tmr >= r_r.disp_wait) begin
        r_nxt.disp_off = 1'b1;
      end
    end

    // read data, valid only in the cycle after the strobe
    // status bits gather at the command address
    r_nxt.rdata = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        `ADDR_CMD: begin
          r_nxt.rdata[`ST_UNLOCKED] = r_r.unlocked;
          r_nxt.rdata[`ST_MOTION_EN] = r_r.motion_en;
          r_nxt.rdata[`ST_MOVING] = r_r.moving;
          r_nxt.rdata[`ST_IDLE] = r_r.idle;
          r_nxt.rdata[`ST_DISP_OFF] = r_r.disp_off;
        end
        `ADDR_TICK_DIV: r_nxt.rdata = r_r.tick_div;
        `ADDR_ON_TIME: r_nxt.rdata = r_r.on_time;
        `ADDR_TRIG_PCT: r_nxt.rdata = {9'h000, r_r.trig_pct};
        `ADDR_START_CNT: r_nxt.rdata = {12'h000, r_r.start_cnt};
        `ADDR_STOP_CNT: r_nxt.rdata = {12'h000, r_r.stop_cnt};
        `ADDR_STOP_HOLD: r_nxt.rdata = r_r.stop_hold;
        `ADDR_IDLE_WAIT: r_nxt.rdata = r_r.idle_wait;
        `ADDR_DISP_WAIT: r_nxt.rdata = r_r.disp_wait;
        `ADDR_NORTH: r_nxt.rdata = r_r.north_angle;
        `ADDR_IDLE_ANGLE: r_nxt.rdata = r_r.idle_angle;
        `ADDR_SENSORS: r_nxt.rdata = {s_trig, s_active};
        default: r_nxt.rdata = 16'h0000;
      endcase
    end
  end

  // *****************************************************************
  // state register
  // *****************************************************************

  // defaults on reset, motion enabled, all outputs low
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r_r <= '0;
      r_r.tick_div <= count_t'(TICK_DIV_RST);
      r_r.on_time <= `RST_ON_TIME;
      r_r.trig_pct <= `RST_TRIG_PCT;
      r_r.start_cnt <= `RST_START_CNT;
      r_r.stop_cnt <= `RST_STOP_CNT;
      r_r.stop_hold <= `RST_STOP_HOLD;
      r_r.idle_wait <= `RST_IDLE_WAIT;
      r_r.disp_wait <= `RST_DISP_WAIT;
      r_r.motion_en <= 1'b1;
    end else begin
      r_r <= r_nxt;
    end
  end

  // *****************************************************************
  // outputs
  // *****************************************************************

  // per-sensor state code
  // triggered outranks active in the view
  always_comb begin
    for (int i = 0; i < `SENSOR_COUNT; i++) begin
      if (s_trig[i]) begin
        sensor_state[i] = SENS_TRIGGERED;
      end else if (s_active[i]) begin
        sensor_state[i] = SENS_ACTIVE;
      end else begin
        sensor_state[i] = SENS_INACTIVE;
      end
    end
  end

  // registered outputs, drive follows moving
  assign reg_rdata = r_r.rdata;
  assign motor_drive_enable = r_r.moving;
  assign idle_mode = r_r.idle;
  assign display_power_off = r_r.disp_off;
  assign north_angle = r_r.north_angle;
  assign idle_angle = r_r.idle_angle;
endmodule // motion_reactivity_qualifier
`default_nettype wire

// ---- src/mrq_map.svh ----
// register map, reset values and timing constants of the motion qualifier
// *****************************************************************
// How it works
// - eight sensors, each qualified on its own
// - no movement inactive, movement makes active
// - triggered after fraction of on-qualify time
// - start needs enough sensors triggered together
// - start needs two neighbouring triggered sensors once start count is two or more
// - start needs one sensor active full time
// - stop condition: triggered count below stop count
// - stop qualified after condition held hold time
// - qualified stop drops drive only while moving
// - unlocked toggle command flips motion enable
// - set-north captures current angle as north
// - idle angle captured like north, motor off
// - stopped for idle wait enters idle
// - idle for display-off wait powers display off
// *****************************************************************
`ifndef MRQ_MAP_SVH
`define MRQ_MAP_SVH

// geometry
`define SENSOR_COUNT 8
`define PAIR_MIN 4'h2

// register word addresses
`define ADDR_CMD 8'h00
`define ADDR_TICK_DIV 8'h01
`define ADDR_ON_TIME 8'h02
`define ADDR_TRIG_PCT 8'h03
`define ADDR_START_CNT 8'h04
`define ADDR_STOP_CNT 8'h05
`define ADDR_STOP_HOLD 8'h06
`define ADDR_IDLE_WAIT 8'h07
`define ADDR_DISP_WAIT 8'h08
`define ADDR_NORTH 8'h09
`define ADDR_IDLE_ANGLE 8'h0a
`define ADDR_SENSORS 8'h0b

// command bits (write) and status bits (read) at ADDR_CMD
`define CMD_UNLOCK 0
`define CMD_LOCK 1
`define CMD_TOGGLE 2
`define CMD_SET_NORTH 3
`define CMD_SET_IDLE 4
`define ST_UNLOCKED 0
`define ST_MOTION_EN 1
`define ST_MOVING 2
`define ST_IDLE 3
`define ST_DISP_OFF 4

// reset values, durations in ticks
`define RST_ON_TIME 16'h03e8
`define RST_TRIG_PCT 7'h28
`define RST_START_CNT 4'h3
`define RST_STOP_CNT 4'h3
`define RST_STOP_HOLD 16'h07d0
`define RST_IDLE_WAIT 16'h2710
`define RST_DISP_WAIT 16'hea60

// fraction arithmetic
`define PCT_MAX 7'h64
`define PCT_DIV 23'h000064

// time base: clock period and one tick, both in ns
`define CLK_PERIOD_NS 25
`define TICK_PERIOD_NS 1000000

`endif

// ---- src/mrq_pkg.sv ----
// types shared by the motion qualifier modules
`default_nettype none
`include "mrq_map.svh"
package mrq_pkg;
  typedef logic [15:0] count_t;
  typedef logic [`SENSOR_COUNT-1:0] sensor_vec_t;
  typedef logic [6:0] pct_t;
  typedef logic [3:0] num_t;

  // per-sensor qualification state as shown to software and outputs
  typedef enum logic [1:0] {
    SENS_INACTIVE = 2'b00,
    SENS_ACTIVE = 2'b01,
    SENS_TRIGGERED = 2'b10
  } sensor_state_t;

  typedef struct packed {
    count_t cnt;
    logic tick;
  } tick_state_t;

  typedef struct packed {
    count_t [`SENSOR_COUNT-1:0] run_cnt;
    sensor_vec_t level;
    sensor_vec_t trig;
    sensor_vec_t full;
  } qual_state_t;

  typedef struct packed {
    sensor_vec_t s_meta;
    sensor_vec_t s_sync;
    count_t tick_div;
    count_t on_time;
    pct_t trig_pct;
    num_t start_cnt;
    num_t stop_cnt;
    count_t stop_hold;
    count_t idle_wait;
    count_t disp_wait;
    logic unlocked;
    logic motion_en;
    logic moving;
    logic idle;
    logic disp_off;
    count_t stop_tmr;
    count_t idle_tmr;
    count_t disp_tmr;
    count_t north_angle;
    count_t idle_angle;
    count_t rdata;
  } top_state_t;
endpackage
`default_nettype wire

// ---- src/sensor_qualifier.sv ----
// per-sensor run-length counters giving active, triggered and full-time
`timescale 1ns/10ps
`default_nettype none
`include "mrq_map.svh"
module sensor_qualifier (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // synchronised sensor levels and time base
  input wire mrq_pkg::sensor_vec_t level,
  input wire logic tick,
  // thresholds in ticks
  input wire mrq_pkg::count_t on_time,
  input wire mrq_pkg::count_t trig_ticks,
  // qualified flags
  output mrq_pkg::sensor_vec_t active,
  output mrq_pkg::sensor_vec_t triggered,
  output mrq_pkg::sensor_vec_t full
);
  import mrq_pkg::*;

  qual_state_t r_r;
  qual_state_t r_nxt;

  // each sensor counts its own continuous movement
  always_comb begin
    r_nxt = r_r;
    r_nxt.level = level;
    for (int i = 0; i < `SENSOR_COUNT; i++) begin
      if (!level[i]) begin
        r_nxt.run_cnt[i] = 16'h0000;
      end else if (tick && r_r.run_cnt[i] < on_time) begin
        r_nxt.run_cnt[i] = count_t'(r_r.run_cnt[i] + 16'h0001);
      end
      r_nxt.trig[i] = level[i] && (r_nxt.run_cnt[i] >= trig_ticks);
      r_nxt.full[i] = level[i] && (r_nxt.run_cnt[i] >= on_time);
    end
  end

  // state register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign active = r_r.level;
  assign triggered = r_r.trig;
  assign full = r_r.full;
endmodule // sensor_qualifier
`default_nettype wire

// ---- src/tick_divider.sv ----
// programmable divider giving the one-cycle tick of the time base
`timescale 1ns/10ps
`default_nettype none
module tick_divider (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // divisor: tick every div + 1 cycles
  input wire mrq_pkg::count_t div,
  // time base pulse
  output logic tick
);
  import mrq_pkg::*;

  tick_state_t r_r;
  tick_state_t r_nxt;

  // count up to the divisor, then pulse and wrap
  always_comb begin
    r_nxt = r_r;
    if (r_r.cnt >= div) begin
      r_nxt.cnt = 16'h0000;
      r_nxt.tick = 1'b1;
    end else begin
      r_nxt.cnt = count_t'(r_r.cnt + 16'h0001);
      r_nxt.tick = 1'b0;
    end
  end

  // state register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign tick = r_r.tick;
endmodule // tick_divider
`default_nettype wire
